// ---- verilog/efcr_device.sv ----
// engine control register bank of the sensor: enables, status, page window, routing
// assumes engines report busy/overrun/events as same-clock levels
`timescale 1ns/1ns
module efcr_device #(
  parameter int PAGE_DEPTH = efcr_pkg::PAGE_DEPTH
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // register port
  efcr_if.device BUS,
  // side controls
  input wire logic PAGE_WRITE_MODE_I,
  input wire logic PAGE_READ_MODE_I,
  input wire logic MASTER_ENGINE_EVENT_ROUTING_I,
  // engine state
  input wire logic ENGINE_BUSY_I,
  input wire logic PASS_OVERRUN_I,
  input wire logic [7:0] ENGINE_EVENT_I,
  input wire logic [7:0] PROGRAM_EVENT_I,
  input wire logic [3:0] CORE_EVENT_I,
  // engine controls
  output logic [3:0] PAGE_SELECT_O,
  output logic EARLY_CORE_RUN_O,
  output logic LATE_CORE_RUN_O,
  output logic SIG_MOTION_RUN_O,
  output logic TILT_RUN_O,
  output logic STEP_RUN_O,
  output logic PROGRAM_RUN_O,
  output logic INT_O
);
  // page window addresses are one byte wide, so at most 256 locations a page
  if (PAGE_DEPTH < 1 || PAGE_DEPTH > 256) begin : g_depth_check
    $error("page depth out of range");
  end

  logic [7:0] bank_sel_ff, en_a_ff, en_b_ff, win_addr_ff, win_data_ff;
  logic [7:0] route_eng_ff, route_prog_ff, route_core_ff;
  logic overrun_ff, idle_ff, rvalid_ff, write_mode_ff, read_mode_ff;
  logic [7:0] rdata_ff;
  logic [7:0] page_mem [efcr_pkg::PAGE_COUNT * PAGE_DEPTH];
  logic access_ok, wr_hit, rd_hit;
  logic [9:0] mem_index;

  assign access_ok = BUS.bank_access & BUS.global_enable;
  assign wr_hit = BUS.req & BUS.wr & access_ok;
  assign rd_hit = BUS.req & ~BUS.wr & access_ok;
  // pages packed back to back at the configured depth
  assign mem_index = 10'(int'(bank_sel_ff[efcr_pkg::POS_PAGE_SEL +: 2]) * PAGE_DEPTH
      + int'(win_addr_ff));

  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m,
      input logic [7:0] fixed);
    masked = (d & m) | (fixed & ~m);
  endfunction

  // configuration registers; reserved bits held at fixed value
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bank_sel_ff <= efcr_pkg::RST_BANK_SELECT;
      en_a_ff <= efcr_pkg::RST_ZERO;
      en_b_ff <= efcr_pkg::RST_ZERO;
      win_addr_ff <= efcr_pkg::RST_ZERO;
      route_eng_ff <= efcr_pkg::RST_ZERO;
      route_prog_ff <= efcr_pkg::RST_ZERO;
      route_core_ff <= efcr_pkg::RST_ZERO;
    end else if (wr_hit) begin
      unique case (BUS.addr)
        efcr_pkg::OFF_BANK_SELECT: bank_sel_ff <= masked(BUS.wdata,
            efcr_pkg::MASK_BANK_SELECT, efcr_pkg::RST_BANK_SELECT);
        efcr_pkg::OFF_ENGINE_EN_A: en_a_ff <= masked(BUS.wdata,
            efcr_pkg::MASK_ENGINE_EN_A, efcr_pkg::RST_ZERO);
        efcr_pkg::OFF_ENGINE_EN_B: en_b_ff <= masked(BUS.wdata,
            efcr_pkg::MASK_ENGINE_EN_B, efcr_pkg::RST_ZERO);
        efcr_pkg::OFF_WINDOW_ADDR: win_addr_ff <= BUS.wdata;
        efcr_pkg::OFF_ENGINE_ROUTE: route_eng_ff <= masked(BUS.wdata,
            efcr_pkg::MASK_ENGINE_ROUTE, efcr_pkg::RST_ZERO);
        efcr_pkg::OFF_PROGRAM_ROUTE: route_prog_ff <= BUS.wdata;
        efcr_pkg::OFF_CORE_ROUTE: route_core_ff <= masked(BUS.wdata,
            efcr_pkg::MASK_CORE_ROUTE, efcr_pkg::RST_ZERO);
        default: ; // status and unmapped writes ignored
      endcase
    end
  end

  // page mode bits sampled from side controls
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      write_mode_ff <= 1'b0;
      read_mode_ff <= 1'b0;
    end else begin
      write_mode_ff <= PAGE_WRITE_MODE_I;
      read_mode_ff <= PAGE_READ_MODE_I;
    end
  end

  // page window: in page write mode, data register writes through to the page
  always_ff @(posedge CLK_I) begin
    if (wr_hit && BUS.addr == efcr_pkg::OFF_WINDOW_DATA && write_mode_ff
        && int'(win_addr_ff) < PAGE_DEPTH) begin
      page_mem[mem_index] <= BUS.wdata;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      win_data_ff <= efcr_pkg::RST_ZERO;
    end else if (wr_hit && BUS.addr == efcr_pkg::OFF_WINDOW_DATA) begin
      win_data_ff <= BUS.wdata;
    end else if (read_mode_ff && win_addr_ff < PAGE_DEPTH) begin
      win_data_ff <= page_mem[mem_index];
    end
  end

  // execution status, live from engines
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      overrun_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      overrun_ff <= PASS_OVERRUN_I;
      idle_ff <= ~ENGINE_BUSY_I;
    end
  end

  // register reads; unmapped or locked bank reads zero
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= BUS.req & ~BUS.wr;
      rdata_ff <= 8'h00;
      if (rd_hit) begin
        unique case (BUS.addr)
          efcr_pkg::OFF_BANK_SELECT: rdata_ff <= bank_sel_ff;
          efcr_pkg::OFF_ENGINE_EN_A: rdata_ff <= en_a_ff;
          efcr_pkg::OFF_ENGINE_EN_B: rdata_ff <= en_b_ff;
          efcr_pkg::OFF_EXEC_STATUS: rdata_ff <= {6'h00, overrun_ff, idle_ff};
          efcr_pkg::OFF_WINDOW_ADDR: rdata_ff <= win_addr_ff;
          efcr_pkg::OFF_WINDOW_DATA: rdata_ff <= win_data_ff;
          efcr_pkg::OFF_ENGINE_ROUTE: rdata_ff <= route_eng_ff;
          efcr_pkg::OFF_PROGRAM_ROUTE: rdata_ff <= route_prog_ff;
          efcr_pkg::OFF_CORE_ROUTE: rdata_ff <= route_core_ff;
          default: rdata_ff <= 8'h00;
        endcase
      end
    end
  end
  assign BUS.rdata = rdata_ff;
  assign BUS.rvalid = rvalid_ff;

  // engine run controls and interrupt pin
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PAGE_SELECT_O <= 4'h0;
      EARLY_CORE_RUN_O <= 1'b0;
      LATE_CORE_RUN_O <= 1'b0;
      SIG_MOTION_RUN_O <= 1'b0;
      TILT_RUN_O <= 1'b0;
      STEP_RUN_O <= 1'b0;
      PROGRAM_RUN_O <= 1'b0;
      INT_O <= 1'b0;
    end else begin
      PAGE_SELECT_O <= bank_sel_ff[efcr_pkg::POS_PAGE_SEL +: 4];
      EARLY_CORE_RUN_O <= en_a_ff[efcr_pkg::POS_EARLY_CORE];
      LATE_CORE_RUN_O <= en_b_ff[efcr_pkg::POS_LATE_CORE];
      SIG_MOTION_RUN_O <= en_a_ff[efcr_pkg::POS_SIG_MOTION];
      TILT_RUN_O <= en_a_ff[efcr_pkg::POS_TILT];
      STEP_RUN_O <= en_a_ff[efcr_pkg::POS_STEP];
      PROGRAM_RUN_O <= en_b_ff[efcr_pkg::POS_PROGRAM];
      INT_O <= MASTER_ENGINE_EVENT_ROUTING_I & (|(route_eng_ff & ENGINE_EVENT_I)
          | |(route_prog_ff & PROGRAM_EVENT_I)
          | |(route_core_ff[3:0] & CORE_EVENT_I));
    end
  end
endmodule

// ---- verilog/efcr_pkg.sv ----
// package for the engine control register bank: offsets, fields, resets
// assumes byte-wide registers reached through the bank's own register port
package efcr_pkg;
  // register offsets
  localparam logic [7:0] OFF_BANK_SELECT = 8'h02;
  localparam logic [7:0] OFF_ENGINE_EN_A = 8'h04;
  localparam logic [7:0] OFF_ENGINE_EN_B = 8'h05;
  localparam logic [7:0] OFF_EXEC_STATUS = 8'h07;
  localparam logic [7:0] OFF_WINDOW_ADDR = 8'h08;
  localparam logic [7:0] OFF_WINDOW_DATA = 8'h09;
  localparam logic [7:0] OFF_ENGINE_ROUTE = 8'h0A;
  localparam logic [7:0] OFF_PROGRAM_ROUTE = 8'h0B;
  localparam logic [7:0] OFF_CORE_ROUTE = 8'h0D;
  // reset values
  localparam logic [7:0] RST_BANK_SELECT = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // writable masks (reserved bits forced to their fixed value)
  localparam logic [7:0] MASK_BANK_SELECT = 8'hF0;
  localparam logic [7:0] MASK_ENGINE_EN_A = 8'hB8;
  localparam logic [7:0] MASK_ENGINE_EN_B = 8'h11;
  localparam logic [7:0] MASK_ENGINE_ROUTE = 8'hB8;
  localparam logic [7:0] MASK_CORE_ROUTE = 8'h0F;
  // field positions
  localparam int POS_PAGE_SEL = 4;
  localparam int POS_EARLY_CORE = 7;
  localparam int POS_SIG_MOTION = 5;
  localparam int POS_TILT = 4;
  localparam int POS_STEP = 3;
  localparam int POS_LATE_CORE = 4;
  localparam int POS_PROGRAM = 0;
  localparam int POS_OVERRUN = 1;
  localparam int POS_IDLE = 0;
  localparam int POS_ROUTE_LC = 7;
  // page geometry
  localparam int PAGE_COUNT = 4;
  localparam int PAGE_DEPTH = 256;
  // host register map over APB (byte address = 4 * index)
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam int CMD_WRITE_POS = 16;
  localparam int CMD_GO_POS = 31;
  typedef enum logic [1:0] {
    EFCR_IDLE,
    EFCR_REQ,
    EFCR_WAIT
  } efcr_host_state_t;
endpackage

// ---- verilog/efcr_if.sv ----
// interface joining the register bank and its host controller
// assumes one common clock; access is a one-cycle strobe with read data next cycle
`timescale 1ns/1ns
interface efcr_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic bank_access;
  logic global_enable;
  modport device (input req, wr, addr, wdata, bank_access, global_enable,
    output rdata, rvalid);
  modport host (output req, wr, addr, wdata, bank_access, global_enable,
    input rdata, rvalid);
endinterface

// ---- verilog/efcr_host.sv ----
// host controller: takes APB orders and drives the bank's register port
// assumes APB master on the same clock; one register access per command
`timescale 1ns/1ns
module efcr_host (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // bank port
  efcr_if.host BUS
);
  efcr_pkg::efcr_host_state_t state_ff;
  logic [31:0] cmd_ff;
  logic [7:0] rdata_ff;
  logic busy_ff, req_ff;
  logic setup, wr_access;

  assign setup = PSEL_I & ~PENABLE_I;
  assign wr_access = PSEL_I & PENABLE_I & PWRITE_I;

  // APB answers in the access cycle; reads of last setup returned
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & (PADDR_I[7:0] != efcr_pkg::APB_CMD)
          & (PADDR_I[7:0] != efcr_pkg::APB_STATUS) & (PADDR_I[7:0] != efcr_pkg::APB_RDATA);
      PRDATA_O <= 32'h0000_0000;
      if (setup && !PWRITE_I) begin
        unique case (PADDR_I[7:0])
          efcr_pkg::APB_CMD: PRDATA_O <= cmd_ff;
          efcr_pkg::APB_STATUS: PRDATA_O <= {31'h0000_0000, busy_ff};
          efcr_pkg::APB_RDATA: PRDATA_O <= {24'h00_0000, rdata_ff};
          default: PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // command register; go bit starts a bank access, ignored while busy
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cmd_ff <= 32'h0000_0000;
      state_ff <= efcr_pkg::EFCR_IDLE;
      busy_ff <= 1'b0;
      req_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      req_ff <= 1'b0;
      unique case (state_ff)
        efcr_pkg::EFCR_IDLE: begin
          if (wr_access && PREADY_O && PADDR_I[7:0] == efcr_pkg::APB_CMD) begin
            cmd_ff <= PWDATA_I;
            if (PWDATA_I[efcr_pkg::CMD_GO_POS]) begin
              state_ff <= efcr_pkg::EFCR_REQ;
              busy_ff <= 1'b1;
            end
          end
        end
        efcr_pkg::EFCR_REQ: begin
          req_ff <= 1'b1;
          state_ff <= cmd_ff[efcr_pkg::CMD_WRITE_POS] ? efcr_pkg::EFCR_IDLE
              : efcr_pkg::EFCR_WAIT;
          busy_ff <= ~cmd_ff[efcr_pkg::CMD_WRITE_POS];
        end
        efcr_pkg::EFCR_WAIT: begin
          if (BUS.rvalid) begin
            rdata_ff <= BUS.rdata;
            busy_ff <= 1'b0;
            state_ff <= efcr_pkg::EFCR_IDLE;
          end
        end
      endcase
    end
  end

  // cmd: [7:0] addr, [15:8] wdata, [16] write, [17] bank access, [18] global enable
  assign BUS.req = req_ff;
  assign BUS.wr = cmd_ff[efcr_pkg::CMD_WRITE_POS];
  assign BUS.addr = cmd_ff[7:0];
  assign BUS.wdata = cmd_ff[15:8];
  assign BUS.bank_access = cmd_ff[17];
  assign BUS.global_enable = cmd_ff[18];
endmodule

// ---- verification/efcr_properties.sv ----
// checker on the bank register port between host and device
// assumes one clock domain; instantiated beside the interface
`timescale 1ns/1ns
module efcr_properties (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // bank port
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic bank_access,
  input wire logic global_enable
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence rd_at(logic [7:0] a);
    req && !wr && addr == a && bank_access && global_enable;
  endsequence
  sequence rd_any;
    req && !wr;
  endsequence
  rd_answer_a: assert property (rd_any |=> rvalid)
    else $error("read not answered");
  no_stray_a: assert property (rvalid |-> $past(req && !wr))
    else $error("answer without read");
  locked_zero_a: assert property (rd_any ##0 !(bank_access && global_enable) |=> rdata == 8'h00)
    else $error("locked read not zero");
  unmapped_zero_a: assert property (rd_at(8'h03) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  sel_fixed_a: assert property (rd_at(8'h02) |=> rdata[3:0] == 4'h1)
    else $error("select fixed bits wrong");
  status_resv_a: assert property (rd_at(8'h07) |=> rdata[7:2] == 6'h00)
    else $error("status upper bits set");
  en_a_resv_a: assert property (rd_at(8'h04) |=> (rdata & 8'h47) == 8'h00)
    else $error("enable a reserved set");
  en_b_resv_a: assert property (rd_at(8'h05) |=> (rdata & 8'hEE) == 8'h00)
    else $error("enable b reserved set");
  core_resv_a: assert property (rd_at(8'h0D) |=> rdata[7:4] == 4'h0)
    else $error("core routing upper set");
endmodule

// ---- verification/tb_embedded_function_control_regs.sv ----
// bench for the engine control bank driven through its host controller
// assumes both ends joined by efcr_if; software speaks APB to the host
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, 32'(e), 32'(g));
module tb_embedded_function_control_regs;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pwm = 0, prm = 0, mer = 0;
  logic busy = 0, ovr = 0, ba = 1, ge = 1, err, serr, pready, int_o;
  logic early, late, sig, tilt, step, prog;
  logic [31:0] paddr = 0, pwdata = 0, prdata, x;
  logic [7:0] ev = 0, pe = 0, rd, d, a;
  logic [3:0] ce = 0, pg;
  logic [7:0] mdl [16];
  logic [7:0] regs [8] = '{8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D};
  int error_cnt = 0, compares = 0, seed = 10500;
  efcr_if bus ();
  efcr_device u_efcr_device (.CLK_I(clk), .RESET_I(rst), .BUS(bus),
    .PAGE_WRITE_MODE_I(pwm), .PAGE_READ_MODE_I(prm), .MASTER_ENGINE_EVENT_ROUTING_I(mer),
    .ENGINE_BUSY_I(busy), .PASS_OVERRUN_I(ovr), .ENGINE_EVENT_I(ev), .PROGRAM_EVENT_I(pe),
    .CORE_EVENT_I(ce), .PAGE_SELECT_O(pg), .EARLY_CORE_RUN_O(early), .LATE_CORE_RUN_O(late),
    .SIG_MOTION_RUN_O(sig), .TILT_RUN_O(tilt), .STEP_RUN_O(step), .PROGRAM_RUN_O(prog),
    .INT_O(int_o));
  efcr_host u_efcr_host (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(err), .BUS(bus));
  efcr_properties u_efcr_properties (.CLK_I(clk), .RESET_I(rst), .req(bus.req),
    .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .bank_access(bus.bank_access), .global_enable(bus.global_enable));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task finish_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1;
    pwr <= w;
    paddr <= {24'h0, ad};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    x = prdata;
    serr = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic bank(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    apb(1, efcr_pkg::APB_CMD, {1'b1, 12'h000, ge, ba, w, wd, ad});
    do begin
      apb(0, efcr_pkg::APB_STATUS, 32'h0);
    end while (x[0] !== 1'b0);
    apb(0, efcr_pkg::APB_RDATA, 32'h0);
    rd = x[7:0];
    if (w && ba && ge && ad != 8'h07) mdl[ad[3:0]] = wd;
  endtask
  // legal values only: reserved zero, select low nibble 0001, at most one core enable
  function automatic logic [7:0] legal(input logic [7:0] ad, input logic [7:0] r);
    case (ad)
      8'h02: legal = {2'b00, r[1:0], 4'h1};
      8'h04: legal = {r[7] & ~mdl[5][4], 1'b0, r[5:3], 3'b000};
      8'h05: legal = {3'b000, r[4] & ~mdl[4][7], 3'b000, r[0]};
      8'h0A: legal = r & 8'hB8;
      8'h0D: legal = r & 8'h0F;
      default: legal = r;
    endcase
  endfunction
  initial begin
    #800000;
    error_cnt++;
    finish_test;
  end
  initial begin
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[2] = 8'h01;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    foreach (regs[i]) begin
      bank(0, regs[i], 8'h00);
      `CHK("reset value", mdl[regs[i][3:0]], rd)
    end
    apb(0, efcr_pkg::APB_CMD, 32'h0);
    `CHK("command word", {1'b1, 12'h000, ge, ba, 1'b0, 8'h00, 8'h0D}, x)
    `CHK("apb no error", 1'b0, serr)
    apb(0, 8'h0C, 32'h0);
    `CHK("apb slave error", 1'b1, serr)
    $display("reset values done");
    repeat (4) begin
      foreach (regs[i]) begin
        bank(1, regs[i], legal(regs[i], 8'($random(seed))));
        bank(0, regs[i], 8'h00);
        `CHK("reg readback", mdl[regs[i][3:0]], rd)
      end
      bank(1, 8'h03, 8'hFF);
      bank(0, 8'h03, 8'h00);
      `CHK("unmapped", 8'h00, rd)
      `CHK("page select", mdl[2][7:4], pg)
      `CHK("runs", {mdl[4][7], mdl[5][4], mdl[4][5:3], mdl[5][0]},
        {early, late, sig, tilt, step, prog})
    end
    $display("readback done");
    for (int k = 0; k < 3; k++) begin
      {ba, ge} = 2'(k);
      bank(1, 8'h0B, ~mdl[11]);
      bank(0, 8'h0B, 8'h00);
      `CHK("locked read", 8'h00, rd)
    end
    {ba, ge} = 2'b11;
    bank(0, 8'h0B, 8'h00);
    `CHK("locked write", mdl[11], rd)
    for (int k = 0; k < 4; k++) begin
      {busy, ovr} <= 2'(k);
      bank(1, 8'h07, 8'hFF);
      bank(0, 8'h07, 8'h00);
      `CHK("exec status", {6'h00, ovr, ~busy}, rd)
    end
    $display("status done");
    a = 8'($random(seed));
    d = 8'($random(seed));
    bank(1, 8'h02, 8'h21);
    pwm <= 1;
    bank(1, 8'h08, a);
    bank(1, 8'h09, d);
    pwm <= 0;
    bank(1, 8'h09, ~d);
    prm <= 1;
    bank(0, 8'h09, 8'h00);
    `CHK("window data", d, rd)
    prm <= 0;
    $display("window done");
    repeat (24) begin
      for (int k = 10; k < 14; k++) begin
        if (k != 12) bank(1, 8'(k), legal(8'(k), 8'($random(seed))));
      end
      {mer, ce, pe, ev} <= 21'($random(seed));
      repeat (2) @(posedge clk);
      `CHK("int pin", mer & (|(ev & mdl[10]) | |(pe & mdl[11]) | |(ce & mdl[13][3:0])),
        int_o)
    end
    $display("routing done");
    finish_test;
  end
endmodule
